// >>> sac_pkg.sv
// package: register map, field layout and timing constants of the adc control
package sac_pkg;
    // ************************************************************
    // register offsets (Avalon word index; byte address = 4*index)
    // ************************************************************
    localparam logic [3:0] OFS_PIN_SEL  = 4'h5;
    localparam logic [3:0] OFS_CONTROL  = 4'h6;
    localparam logic [3:0] OFS_OFFSET   = 4'h7;
    localparam logic [3:0] OFS_RES_HIGH = 4'h8;
    localparam logic [3:0] OFS_RES_LOW  = 4'h9;
    localparam logic [3:0] OFS_STATUS   = 4'ha;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTL_REF_BIT   = 7;
    localparam int CTL_PRE_HI    = 6;
    localparam int CTL_PRE_LO    = 5;
    localparam int CTL_RUN_BIT   = 4;
    localparam int CTL_PWR_BIT   = 3;
    localparam int CTL_CH_HI     = 2;
    localparam int OFS_CAL_BIT   = 7;
    localparam int OFS_SIGN_BIT  = 6;
    localparam int OFS_MAG_HI    = 5;
    localparam int OFS_MAG_LO    = 3;
    localparam int STS_DONE_BIT  = 0;
    localparam int STS_WAKE_BIT  = 1;
    localparam int STS_SLEEP_BIT = 2;
    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic [7:0] PIN_SEL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] OFFSET_RESET  = 8'h00;
    localparam logic [1:0] PRE_DIV4  = 2'h0;
    localparam logic [1:0] PRE_DIV1  = 2'h1;
    localparam logic [1:0] PRE_DIV16 = 2'h2;
    localparam logic [1:0] PRE_DIV2  = 2'h3;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ        = 200;
    localparam int BIT_TIME_US    = 1;
    localparam int CONV_TIME_US   = 16;
    localparam int RES_BITS       = 10;
    localparam int BIT_CYCLES     = BIT_TIME_US * CLK_MHZ;
    localparam int CONV_BIT_SLOTS = CONV_TIME_US / BIT_TIME_US;
    typedef enum logic [1:0] {
        SAC_IDLE   = 2'b00,
        SAC_SAMPLE = 2'b01,
        SAC_CONV   = 2'b11,
        SAC_DONE   = 2'b10
    } sac_state_type;
    // converter-facing control bundle
    typedef struct packed {
        logic [7:0] pin_analog;
        logic       ref_external;
        logic       powered;
        logic [2:0] channel;
        logic       cal_enable;
        logic       cal_positive;
        logic [2:0] cal_magnitude;
    } sac_ana_ctl_type;
endpackage

// >>> sac_clkdiv.sv
// conversion clock prescaler: one-cycle tick at the selected divide ratio
module sac_clkdiv
    import sac_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       clk_en,
    // control
    input  wire logic       run,
    input  wire logic [1:0] sel,
    // tick out
    output logic            tick
);
    logic [3:0] cnt_q;
    logic [3:0] limit;

    // prescale code to terminal count
    always_comb begin
        case (sel)
            PRE_DIV1:  limit = 4'h0;
            PRE_DIV2:  limit = 4'h1;
            PRE_DIV16: limit = 4'hf;
            default:   limit = 4'h3;
        endcase
    end

    // free counter restarted whenever the run is idle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
        end else if (clk_en) begin
            if (!run || cnt_q >= limit) begin
                cnt_q <= 4'h0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    assign tick = run && (cnt_q >= limit);
endmodule

// >>> sac_top.sv
// sar adc control: registers, sequencer, successive approximation and results
//
// Design decision made here: the Avalon-MM slave port.
module sac_top
    import sac_pkg::*;
#(
    parameter int BIT_CYC = BIT_CYCLES
)(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  clk_en,
    // avalon-mm slave
    input  wire logic [5:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    // system
    input  wire logic                  sleep,
    output logic                       wake,
    // analog front end
    output sac_ana_ctl_type            ana_ctl,
    output logic                       sample_hold,
    output logic [RES_BITS-1:0]        dac_trial,
    input  wire logic                  comp_high
);
    // ************************************************************
    // state
    // ************************************************************
    logic [7:0]          pin_sel_q;
    logic                ref_sel_q;
    logic [1:0]          pre_sel_q;
    logic                run_q;
    logic                power_q;
    logic [2:0]          chan_q;
    logic                cal_en_q;
    logic                cal_pos_q;
    logic [2:0]          cal_mag_q;
    logic                done_q;
    logic                wake_en_q;
    logic                shut_q;
    logic [RES_BITS-1:0] result_q;
    logic [RES_BITS-1:0] sar_q;
    logic [RES_BITS-1:0] trial_q;
    logic [4:0]          slot_q;
    logic [15:0]         bit_cnt_q;
    logic                ack_q;
    logic [31:0]         rdata_q;
    logic                wake_q;
    sac_state_type       state_q;

    logic [3:0]          word;
    logic                req;
    logic                wr_hit;
    logic                finish;
    logic                bit_tick;
    logic                conv_tick;
    logic                powered;
    logic                busy;

    // ************************************************************
    // bus decode
    // ************************************************************
    // one wait cycle for every access keeps read data registered
    assign word            = avs_address[5:2];
    assign req             = (avs_read || avs_write) && !ack_q;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign wr_hit          = avs_write && req && avs_byteenable[0];
    assign avs_readdata    = rdata_q;

    // acknowledge strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else if (clk_en) begin
            ack_q <= req;
        end
    end

    // read mux, unmapped words read zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else if (clk_en && req && avs_read) begin
            case (word)
                OFS_PIN_SEL:  rdata_q <= {24'h0, pin_sel_q};
                OFS_CONTROL:  rdata_q <= {24'h0, ref_sel_q, pre_sel_q,
                                          run_q, power_q, chan_q};
                OFS_OFFSET:   rdata_q <= {24'h0, cal_en_q, cal_pos_q,
                                          cal_mag_q, 3'h0};
                OFS_RES_HIGH: rdata_q <= {24'h0, result_q[9:2]};
                OFS_RES_LOW:  rdata_q <= {24'h0, result_q[1:0], 6'h0};
                OFS_STATUS:   rdata_q <= {29'h0, shut_q, wake_en_q, done_q};
                default:      rdata_q <= 32'h0;
            endcase
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    // pin select
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_sel_q <= PIN_SEL_RESET;
        end else if (clk_en && wr_hit && word == OFS_PIN_SEL) begin
            pin_sel_q <= avs_writedata[7:0];
        end
    end

    // control fields other than run
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ref_sel_q <= CONTROL_RESET[CTL_REF_BIT];
            pre_sel_q <= CONTROL_RESET[CTL_PRE_HI:CTL_PRE_LO];
            power_q   <= CONTROL_RESET[CTL_PWR_BIT];
            chan_q    <= CONTROL_RESET[CTL_CH_HI:0];
        end else if (clk_en && wr_hit && word == OFS_CONTROL) begin
            ref_sel_q <= avs_writedata[CTL_REF_BIT];
            pre_sel_q <= avs_writedata[CTL_PRE_HI:CTL_PRE_LO];
            power_q   <= avs_writedata[CTL_PWR_BIT];
            // channel locked while run is set or until the done flag is cleared
            if (!done_q && !run_q) begin
                chan_q <= avs_writedata[CTL_CH_HI:0];
            end
        end
    end

    // offset calibration, low bits are not stored
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cal_en_q  <= OFFSET_RESET[OFS_CAL_BIT];
            cal_pos_q <= OFFSET_RESET[OFS_SIGN_BIT];
            cal_mag_q <= OFFSET_RESET[OFS_MAG_HI:OFS_MAG_LO];
        end else if (clk_en && wr_hit && word == OFS_OFFSET) begin
            cal_en_q  <= avs_writedata[OFS_CAL_BIT];
            cal_pos_q <= avs_writedata[OFS_SIGN_BIT];
            cal_mag_q <= avs_writedata[OFS_MAG_HI:OFS_MAG_LO];
        end
    end

    // wake enable in status word
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wake_en_q <= 1'b0;
        end else if (clk_en && wr_hit && word == OFS_STATUS) begin
            wake_en_q <= avs_writedata[STS_WAKE_BIT];
        end
    end

    // ************************************************************
    // run bit and done flag
    // ************************************************************
    // the written value must set power and sleep shutdown must be off to start
    assign powered = power_q && !shut_q;
    assign busy    = (state_q != SAC_IDLE);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
        end else if (clk_en) begin
            if (finish) begin
                run_q <= 1'b0;
            end else if (wr_hit && word == OFS_CONTROL
                         && avs_writedata[CTL_RUN_BIT]
                         && avs_writedata[CTL_PWR_BIT] && !shut_q) begin
                run_q <= 1'b1;
            end else if (!powered) begin
                run_q <= 1'b0;
            end
        end
    end

    // done flag: set beats software clear by writing status bit 0 as one
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
        end else if (clk_en) begin
            if (finish) begin
                done_q <= 1'b1;
            end else if (wr_hit && word == OFS_STATUS
                         && avs_writedata[STS_DONE_BIT]) begin
                done_q <= 1'b0;
            end
        end
    end

    // sleep shutdown and wake pulse
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shut_q <= 1'b0;
            wake_q <= 1'b0;
        end else if (clk_en) begin
            wake_q <= finish && sleep && wake_en_q;
            if (finish && sleep && !wake_en_q) begin
                shut_q <= 1'b1;
            end else if (!sleep) begin
                shut_q <= 1'b0;
            end
        end
    end
    assign wake = wake_q;

    // ************************************************************
    // sequencer
    // ************************************************************
    sac_clkdiv u_div (
        .clock  (clock),
        .rst    (rst),
        .clk_en (clk_en),
        .run    (busy),
        .sel    (pre_sel_q),
        .tick   (conv_tick)
    );

    // bit timer: fixed bit time, independent of the prescaler; the
    // prescaled tick only paces the sample_hold strobe during the sample bit
    assign bit_tick = busy && (bit_cnt_q == 16'(BIT_CYC - 1));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bit_cnt_q <= 16'h0;
        end else if (clk_en) begin
            if (!busy || bit_tick) begin
                bit_cnt_q <= 16'h0;
            end else begin
                bit_cnt_q <= bit_cnt_q + 16'h1;
            end
        end
    end

    // conversion runs on in sleep: sleep gates nothing here
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= SAC_IDLE;
            slot_q  <= 5'h0;
        end else if (clk_en) begin
            case (state_q)
                SAC_IDLE: begin
                    if (run_q && powered) begin
                        state_q <= SAC_SAMPLE;
                    end
                    slot_q <= 5'h0;
                end
                SAC_SAMPLE: begin
                    if (bit_tick) begin
                        state_q <= SAC_CONV;
                        slot_q  <= 5'h1;
                    end
                end
                SAC_CONV: begin
                    if (!powered) begin
                        state_q <= SAC_IDLE;
                    end else if (bit_tick) begin
                        if (slot_q == 5'(CONV_BIT_SLOTS - 1)) begin
                            state_q <= SAC_DONE;
                        end
                        slot_q <= slot_q + 5'h1;
                    end
                end
                SAC_DONE: state_q <= SAC_IDLE;
                default:  state_q <= SAC_IDLE;
            endcase
        end
    end
    assign finish = (state_q == SAC_DONE);

    // successive approximation: slots 1..10 decide msb first
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sar_q   <= '0;
            trial_q <= '0;
        end else if (clk_en) begin
            if (state_q == SAC_SAMPLE) begin
                sar_q   <= '0;
                trial_q <= 10'h200;
            end else if (state_q == SAC_CONV && bit_tick
                         && slot_q <= 5'(RES_BITS)) begin
                // keep the trial bit when input is above the dac
                sar_q   <= comp_high ? trial_q : (trial_q ^ (trial_q &
                           ~sar_q & -trial_q));
                trial_q <= (comp_high ? trial_q : sar_q)
                           | ((trial_q & ~sar_q & -trial_q) >> 1);
            end
        end
    end
    assign dac_trial   = trial_q;
    assign sample_hold = (state_q == SAC_SAMPLE) && conv_tick;

    // both result halves load in one edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            result_q <= '0;
        end else if (clk_en && finish) begin
            result_q <= sar_q;
        end
    end

    // analog control bundle
    always_comb begin
        ana_ctl.pin_analog    = pin_sel_q;
        ana_ctl.ref_external  = ref_sel_q;
        ana_ctl.powered       = powered;
        ana_ctl.channel       = chan_q;
        ana_ctl.cal_enable    = cal_en_q;
        ana_ctl.cal_positive  = cal_pos_q;
        ana_ctl.cal_magnitude = cal_mag_q;
    end

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_finish;
        clk_en && finish;
    endsequence
    property p_done_set;
        @(posedge clock) disable iff (rst)
        s_finish |=> done_q && !run_q;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("done flag or run bit wrong after finish");
    property p_run_hold;
        @(posedge clock) disable iff (rst)
        (run_q && powered && !finish && clk_en) |=> run_q;
    endproperty
    a_run_hold: assert property (p_run_hold)
        else $error("run bit dropped before finish");
    property p_chan_lock;
        @(posedge clock) disable iff (rst)
        (done_q || run_q) |=> $stable(chan_q);
    endproperty
    a_chan_lock: assert property (p_chan_lock)
        else $error("channel changed while locked");
    property p_res_stable;
        @(posedge clock) disable iff (rst)
        !finish |=> $stable(result_q);
    endproperty
    a_res_stable: assert property (p_res_stable)
        else $error("result changed outside completion");
    property p_ofs_zero;
        @(posedge clock) disable iff (rst)
        (req && avs_read && word == OFS_OFFSET && clk_en)
        |=> rdata_q[2:0] == 3'h0;
    endproperty
    a_ofs_zero: assert property (p_ofs_zero)
        else $error("offset low bits not zero");
    property p_pin_map;
        @(posedge clock) disable iff (rst)
        ana_ctl.pin_analog == pin_sel_q;
    endproperty
    a_pin_map: assert property (p_pin_map)
        else $error("pin analog map mismatch");
    property p_unpowered;
        @(posedge clock) disable iff (rst)
        (!powered && state_q == SAC_IDLE && clk_en) |=> !busy;
    endproperty
    a_unpowered: assert property (p_unpowered)
        else $error("conversion started unpowered");
    property p_conv_len;
        @(posedge clock) disable iff (rst)
        ($rose(state_q == SAC_CONV) && clk_en) |->
        (state_q == SAC_CONV) [*8];
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion ended too soon");
endmodule

// >>> sac_fe_model.sv
// analog front end model: channel sources and comparator
module sac_fe_model
    import sac_pkg::*;
(
    // converter side
    input  wire sac_ana_ctl_type ana_ctl,
    input  wire logic [9:0]      dac_trial,
    output logic                 comp_high,
    // analog sources
    input  wire logic [9:0]      vin [8]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] level;
    // a digital pin or an unpowered converter gives no signal
    always_comb begin
        level = 10'h000;
        if (ana_ctl.pin_analog[ana_ctl.channel]) begin
            level = vin[ana_ctl.channel];
        end
        if (!ana_ctl.powered) begin
            level = 10'h000;
        end
        comp_high = (level >= dac_trial);
    end
endmodule

// >>> sar_adc_control_bench.sv
// self-checking bench of the adc control block
module sar_adc_control_bench
    import sac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BC   = 4;
    localparam int CONV = 16 * BC;
    logic            clock, rst, clk_en, sleep, wake, comp_high;
    logic            sample_hold;
    logic            avs_read, avs_write, avs_waitrequest;
    logic [5:0]      avs_address;
    logic [31:0]     avs_writedata, avs_readdata;
    logic [3:0]      avs_byteenable;
    logic [9:0]      dac_trial, v;
    logic [9:0]      vin [8];
    sac_ana_ctl_type ana_ctl;
    logic [31:0]     seed;
    logic [7:0]      c, rdat;
    logic [11:0]     exp_q[$];
    logic [11:0]     note;
    logic            rd_ok = 1'b0;
    logic            wr_lo = 1'b0;
    int              cyc = 0;
    int              t0, wn, err_total = 0, tests_run = 0, wake_n = 0;
    int              sh0, dv, sh_n = 0;

    sac_top #(.BIT_CYC(BC)) dut (.clock(clock), .rst(rst), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sleep(sleep), .wake(wake),
        .ana_ctl(ana_ctl), .sample_hold(sample_hold), .dac_trial(dac_trial),
        .comp_high(comp_high));
    sac_fe_model fe (.ana_ctl(ana_ctl), .dac_trial(dac_trial),
        .comp_high(comp_high), .vin(vin));

    // clock at 200 MHz
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // free cycle count, wake and sample pulses, waitrequest before the edge
    always @(posedge clock) cyc <= cyc + 1;
    always @(posedge clock) if (wake === 1'b1) wake_n <= wake_n + 1;
    always @(negedge clock) if (sample_hold === 1'b1) sh_n <= sh_n + 1;
    always @(negedge clock) wr_lo = (avs_waitrequest === 1'b0);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic cmp(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    // request held until the edge that sees waitrequest low
    task automatic bus(input logic [3:0] idx, input logic wr,
                       input logic [7:0] d, input logic [3:0] be,
                       input logic ck);
        avs_address    <= {idx, 2'b00};
        avs_writedata  <= {24'h000000, d};
        avs_byteenable <= be;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do @(posedge clock); while (!wr_lo);
        rd_ok = !wr && ck;
        rdat  = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
        rd_ok = 1'b0;
    endtask
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d, 4'h1, 1'b0);
    endtask
    task automatic rd(input logic [3:0] idx, input logic [7:0] e);
        exp_q.push_back({idx, e});
        bus(idx, 1'b0, 8'h00, 4'h0, 1'b1);
    endtask
    // polling costs three cycles a read, bounded by the cycle count
    task automatic wait_done();
        do bus(4'ha, 1'b0, 8'h00, 4'h0, 1'b0);
        while (rdat[0] !== 1'b1 && cyc - t0 < 400);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // scoreboard: the oldest note against each answered read issued by rd; wait_done polls go unchecked
    always @(negedge clock) begin
        if (rd_ok) begin
            note = exp_q.pop_front();
            cmp($sformatf("reg %h", note[11:8]), note[7:0],
                avs_readdata[7:0]);
        end
    end
    // watchdog well beyond a dozen conversions
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        complete_run();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {rst, clk_en, sleep, avs_read, avs_write} = 5'b11000;
        {avs_address, avs_writedata, avs_byteenable} = '0;
        seed = 32'h870c5dbc;
        foreach (vin[i]) vin[i] = 10'h000;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int i = 4; i < 12; i++) rd(i[3:0], 8'h00);
        wr(4'hb, 8'hff);
        rd(4'hb, 8'h00);
        seed = xs(seed);
        wr(4'h5, seed[7:0]);
        rd(4'h5, seed[7:0]);
        cmp("pins", seed[7:0], ana_ctl.pin_analog);
        wr(4'h7, seed[15:8] | 8'h07);
        rd(4'h7, seed[15:8] & 8'hf8);
        cmp("cal", seed[15:8] & 8'hf8, {ana_ctl.cal_enable,
            ana_ctl.cal_positive, ana_ctl.cal_magnitude, 3'h0});
        wr(4'h5, 8'hff);
        bus(4'h5, 1'b1, 8'h00, 4'he, 1'b0);
        rd(4'h5, 8'hff);
        for (int ch = 0; ch < 8; ch++) begin
            seed = xs(seed);
            v = seed[9:0];
            vin[ch] <= v;
            c = {ch[2], ch[1:0], 2'b01, ch[2:0]};
            wr(4'h6, c);
            cmp("ctl", {3'h0, c[7], c[3], c[2:0]}, {3'h0,
                ana_ctl.ref_external, ana_ctl.powered, ana_ctl.channel});
            repeat (4) @(posedge clock);
            // sample strobes in one bit time follow the divide ratio
            dv = (ch[1:0] == 2'h0) ? 4 : (ch[1:0] == 2'h1) ? 1
                : (ch[1:0] == 2'h2) ? 16 : 2;
            sh0 = sh_n;
            wr(4'h6, c | 8'h10);
            t0 = cyc;
            rd(4'h6, c | 8'h10);
            wr(4'h6, (c & 8'hef) ^ 8'h07);
            rd(4'h6, c | 8'h10);
            wait_done();
            cmp("time", 8'h01, {7'h00, (cyc - t0 >= CONV)
                && (cyc - t0 <= CONV + 8)});
            cmp("div", 8'(BC / dv), 8'(sh_n - sh0));
            rd(4'h8, v[9:2]);
            rd(4'h9, {v[1:0], 6'h00});
            rd(4'h6, c);
            wr(4'h6, c ^ 8'h07);
            rd(4'h6, c);
            wr(4'ha, 8'h01);
            rd(4'ha, 8'h00);
            repeat (32) @(posedge clock);
        end
        wr(4'h6, 8'h10);
        rd(4'h6, 8'h00);
        rd(4'h8, v[9:2]);
        cmp("pwr", 8'h00, {7'h00, ana_ctl.powered});
        sleep <= 1'b1;
        wr(4'ha, 8'h02);
        wn = wake_n;
        wr(4'h6, 8'h18);
        t0 = cyc;
        wait_done();
        rd(4'h8, vin[0][9:2]);
        cmp("wake", 8'h01, 8'(wake_n - wn));
        wr(4'ha, 8'h01);
        wr(4'h6, 8'h18);
        t0 = cyc;
        wait_done();
        rd(4'ha, 8'h05);
        cmp("off", 8'h00, {7'h00, ana_ctl.powered});
        sleep <= 1'b0;
        repeat (3) @(posedge clock);
        cmp("on", 8'h01, {7'h00, ana_ctl.powered});
        rd(4'ha, 8'h01);
        repeat (4) @(posedge clock);
        complete_run();
    end
endmodule
